// ---- cie_pkg.sv ----
/*
 * constants for the clear-instruction execution block
 * assumes an 8-bit data memory word and a single instruction clock
 */
`default_nettype none

package cie_pkg;

	localparam int unsigned DATA_W  = 8;
	localparam int unsigned BITSEL_W = 3;
	localparam int unsigned ADDR_W  = 8;

	// op codes delivered by the decode stage
	localparam logic [2:0] OP_NONE     = 3'h0;
	localparam logic [2:0] OP_BIT_CLR  = 3'h1;
	localparam logic [2:0] OP_WDT_CLR  = 3'h2;
	localparam logic [2:0] OP_PRE_ONE  = 3'h3;
	localparam logic [2:0] OP_PRE_TWO  = 3'h4;

	localparam logic FLAG_CLEARED = 1'h0;

	// last accepted pre-clear: one-hot
	typedef enum logic [1:0] {
		CIE_LAST_ONE = 2'h1,
		CIE_LAST_TWO = 2'h2
	} cie_last_t;

endpackage

`default_nettype wire

// ---- cie_bit_clear.sv ----
/*
 * single-bit clear datapath: read word in, cleared word out
 * assumes the caller holds the addressed word valid for the cycle
 */
`timescale 1ns/1ps
`default_nettype none

module cie_bit_clear #(
	parameter int unsigned DATA_W   = cie_pkg::DATA_W,
	parameter int unsigned BITSEL_W = cie_pkg::BITSEL_W
) (
	// operand
	input  wire logic [DATA_W-1:0]   word_in,
	input  wire logic [BITSEL_W-1:0] bit_sel,
	// result
	output logic      [DATA_W-1:0]   word_out
);

	genvar g;
	generate
		for (g = 0; g < DATA_W; g++)
		begin : g_bit
			// only the selected lane is forced low
			assign word_out[g] = (bit_sel == BITSEL_W'(g)) ? 1'h0 : word_in[g];
		end
	endgenerate

endmodule // cie_bit_clear

`default_nettype wire

// ---- cie_exec.sv ----
/*
 * execution logic for the clear instruction group of a small core
 * assumes one decoded op per cycle from the decode stage, synchronous to ref_clk;
 * the watchdog counter itself lives outside and obeys wdt_restart
 */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - A bit clear forces only the selected bit of the addressed word to zero.
// - A bit clear leaves every status flag as it was.
// - A watchdog clear restarts the counter and zeroes the timeout and power-down flags.
// - The first pre-clear acts only when it follows the second pre-clear or reset.
// - The second pre-clear acts only when it follows the first pre-clear.
// - Each pre-clear that alternates with the last one restarts the counter and zeroes both flags.
module cie_exec #(
	parameter int unsigned DATA_W   = cie_pkg::DATA_W,
	parameter int unsigned BITSEL_W = cie_pkg::BITSEL_W,
	parameter int unsigned ADDR_W   = cie_pkg::ADDR_W
) (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	// decoded instruction
	input  wire logic [2:0]          op_code,
	input  wire logic [ADDR_W-1:0]   mem_addr,
	input  wire logic [BITSEL_W-1:0] bit_sel,
	input  wire logic [DATA_W-1:0]   mem_rdata,
	// flag events from the watchdog and sleep logic
	input  wire logic                timeout_set,
	input  wire logic                power_down_set,
	// data memory write-back
	output logic                     mem_we,
	output logic      [ADDR_W-1:0]   mem_waddr,
	output logic      [DATA_W-1:0]   mem_wdata,
	// watchdog and status
	output logic                     wdt_restart,
	output logic                     timeout_flag,
	output logic                     power_down_flag
);

	////////////////////////////////////////////////////////////////////////////
	// internal signals

	// pairing state: which pre-clear was taken last
	cie_pkg::cie_last_t last_pre;

	// datapath result of the bit clear
	logic [DATA_W-1:0]  cleared_word;

	// decoded ops
	logic               op_bit_clr;
	logic               op_wdt_clr;
	logic               op_pre_one;
	logic               op_pre_two;

	// pairing outcome
	logic               pre_one_ok;
	logic               pre_two_ok;
	logic               clear_wdt;

	////////////////////////////////////////////////////////////////////////////
	// op decoding, shared by datapath, pairing and flags

	function automatic logic op_is(
		input logic [2:0] op,
		input logic [2:0] code
	);
		return (op == code);
	endfunction

	// a pre-clear is taken only when the other one was taken last
	function automatic logic alternates(
		input cie_pkg::cie_last_t last,
		input cie_pkg::cie_last_t needed
	);
		return (last == needed);
	endfunction

	assign op_bit_clr = op_is(op_code, cie_pkg::OP_BIT_CLR);
	assign op_wdt_clr = op_is(op_code, cie_pkg::OP_WDT_CLR);
	assign op_pre_one = op_is(op_code, cie_pkg::OP_PRE_ONE);
	assign op_pre_two = op_is(op_code, cie_pkg::OP_PRE_TWO);

	////////////////////////////////////////////////////////////////////////////
	// bit clear datapath

	cie_bit_clear #(
		.DATA_W   (DATA_W),
		.BITSEL_W (BITSEL_W)
	) u_bit_clear (
		.word_in  (mem_rdata),
		.bit_sel  (bit_sel),
		.word_out (cleared_word)
	);

	////////////////////////////////////////////////////////////////////////////
	// pre-clear pairing

	assign pre_one_ok = op_pre_one && alternates(last_pre, cie_pkg::CIE_LAST_TWO);
	assign pre_two_ok = op_pre_two && alternates(last_pre, cie_pkg::CIE_LAST_ONE);

	// plain watchdog clear does not touch the pairing state
	assign clear_wdt  = op_wdt_clr || pre_one_ok || pre_two_ok;

	// state starts as "last was two" so the first one-op of a pair is taken;
	// a repeated op is seen as already accepted and changes nothing
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			last_pre <= cie_pkg::CIE_LAST_TWO;
		end
		else if (op_pre_one)
		begin
			last_pre <= cie_pkg::CIE_LAST_ONE;
		end
		else if (op_pre_two)
		begin
			last_pre <= cie_pkg::CIE_LAST_TWO;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// watchdog restart pulse

	// one cycle per effective clear; the counter outside restarts from zero
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wdt_restart <= 1'h0;
		end
		else
		begin
			wdt_restart <= clear_wdt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status flags

	// a clear instruction wins over a same-cycle set since software asked
	// for the clear explicitly and the counter restarts anyway
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			timeout_flag <= cie_pkg::FLAG_CLEARED;
		end
		else if (clear_wdt)
		begin
			timeout_flag <= cie_pkg::FLAG_CLEARED;
		end
		else if (timeout_set)
		begin
			// bit clear never reaches here as a flag writer
			timeout_flag <= 1'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			power_down_flag <= cie_pkg::FLAG_CLEARED;
		end
		else if (clear_wdt)
		begin
			power_down_flag <= cie_pkg::FLAG_CLEARED;
		end
		else if (power_down_set)
		begin
			power_down_flag <= 1'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// data memory write-back

	// strobe lasts one cycle per bit clear
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_we <= 1'h0;
		end
		else
		begin
			mem_we <= op_bit_clr;
		end
	end

	// address and word hold until the next bit clear
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_waddr <= '0;
			mem_wdata <= '0;
		end
		else if (op_bit_clr)
		begin
			mem_waddr <= mem_addr;
			mem_wdata <= cleared_word;
		end
	end

endmodule // cie_exec

`default_nettype wire

// ---- cie_exec_monitor.sv ----
/* concurrent checks on cie_exec ports; bound in from the bench */
`timescale 1ns/1ps
`default_nettype none
module cie_exec_monitor (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic [2:0] op_code,
	input wire logic [7:0] mem_addr,
	input wire logic [2:0] bit_sel,
	input wire logic [7:0] mem_rdata,
	input wire logic       timeout_set,
	input wire logic       power_down_set,
	input wire logic       mem_we,
	input wire logic [7:0] mem_waddr,
	input wire logic [7:0] mem_wdata,
	input wire logic       wdt_restart,
	input wire logic       timeout_flag,
	input wire logic       power_down_flag
);
	logic lt; // last pre-clear seen was the second
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n) lt <= 1'h1;
		else if (op_code == 3'h3) lt <= 1'h0;
		else if (op_code == 3'h4) lt <= 1'h1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	AST_BIT: assert property (op_code == 3'h1 |=> mem_we && mem_waddr == $past(mem_addr) &&
		mem_wdata == ($past(mem_rdata) & ~(8'h1 << $past(bit_sel)))) else $error("bad bit clear");
	AST_FLG: assert property (op_code == 3'h1 && !timeout_set && !power_down_set |=>
		$stable({timeout_flag, power_down_flag})) else $error("flags moved");
	AST_WDT: assert property (op_code == 3'h2 |=> wdt_restart && !timeout_flag && !power_down_flag)
		else $error("clear missed");
	AST_ONE: assert property (op_code == 3'h3 && !lt |=> !wdt_restart) else $error("repeat acted");
	AST_TWO: assert property (op_code == 3'h4 && lt |=> !wdt_restart) else $error("repeat acted");
	AST_PAIR: assert property (op_code inside {3'h3, 3'h4} && (op_code == 3'h3) == lt |=>
		wdt_restart && !timeout_flag && !power_down_flag) else $error("pair missed");
	AST_CAUSE: assert property (wdt_restart |-> $past(op_code) inside {3'h2, 3'h3, 3'h4})
		else $error("stray restart");
	cover property (op_code == 3'h1);
	cover property (op_code == 3'h3 && !lt);
	cover property (op_code == 3'h4 && !lt);
endmodule // cie_exec_monitor
`default_nettype wire

// ---- clear_instruction_exec_bench.sv ----
/* bench for cie_exec; assumes the design and monitor files compile first */
`timescale 1ns/1ps
`default_nettype none
module clear_instruction_exec_bench;
	logic ref_clk = 1'h0, rst_n = 1'h0, timeout_set = 1'h0, power_down_set = 1'h0;
	logic [2:0] op_code = 3'h0, bit_sel = 3'h0;
	logic [7:0] mem_addr = 8'h0, mem_rdata = 8'h0, mem_waddr, mem_wdata;
	logic mem_we, wdt_restart, timeout_flag, power_down_flag;
	int n_fail = 0, num_checks = 0;
	cie_exec DUT (.*);
	always #12.5 ref_clk = ~ref_clk;
	task end_of_test;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task step(input logic [2:0] o, input logic [2:0] s, input logic [7:0] d, input logic f);
		@(posedge ref_clk);
		#1;
		op_code = o; bit_sel = s; mem_rdata = d; mem_addr = ~d; timeout_set = f; power_down_set = f;
	endtask
	// same-cycle set shows whether an op acted: clear wins
	task t_pre;
		logic [2:0] ops [9] = '{2, 3, 3, 4, 4, 2, 3, 4, 3};
		logic exp [9] = '{1, 1, 0, 1, 0, 1, 1, 1, 1};
		for (int i = 0; i < 9; i++)
		begin
			step(ops[i], 3'h0, 8'h0, 1'h1);
			step(3'h0, 3'h0, 8'h0, 1'h0);
			chk({wdt_restart, timeout_flag, power_down_flag}, {exp[i], ~exp[i], ~exp[i]}); // to
		end
	endtask
	task t_bits;
		for (int i = 0; i < 8; i++)
		begin
			step(3'h0, 3'h0, 8'h0, 1'h1);
			step(3'h1, i[2:0], 8'ha5 | (8'h1 << i), 1'h0);
			step(3'h0, 3'h0, 8'h0, 1'h0);
			chk(mem_wdata, 8'ha5 & ~(8'h1 << i));
			chk(mem_waddr, ~(8'ha5 | (8'h1 << i)));
			chk({mem_we, timeout_flag, power_down_flag}, 8'h7);
			step(3'h0, 3'h0, 8'h0, 1'h0);
			chk(mem_we, 8'h0);
		end
	endtask
	// mid-run reset: outputs drop, pairing restarts as if the second came last
	task t_reset;
		step(3'h3, 3'h0, 8'h0, 1'h0);
		step(3'h0, 3'h0, 8'h0, 1'h1);
		step(3'h0, 3'h0, 8'h0, 1'h0);
		rst_n = 1'h0;
		#1;
		chk({mem_we, wdt_restart, timeout_flag, power_down_flag}, 8'h0);
		chk(mem_wdata, 8'h0);
		@(posedge ref_clk);
		#1 rst_n = 1'h1;
		step(3'h3, 3'h0, 8'h0, 1'h1);
		step(3'h0, 3'h0, 8'h0, 1'h0);
		chk({wdt_restart, timeout_flag, power_down_flag}, 8'h4);
		step(3'h4, 3'h0, 8'h0, 1'h1);
		step(3'h0, 3'h0, 8'h0, 1'h0);
		chk({wdt_restart, timeout_flag, power_down_flag}, 8'h4);
	endtask
	initial
	begin
		repeat (6) @(posedge ref_clk);
		#1 rst_n = 1'h1;
		t_pre();
		t_bits();
		t_reset();
		end_of_test();
	end
	initial
	begin
		#20000;
		n_fail++;
		end_of_test();
	end
endmodule // clear_instruction_exec_bench
bind cie_exec cie_exec_monitor mon (.*);
`default_nettype wire
